/* rtl/dmba_defines.vh */
// constants for the data memory bank addressing block
// assumes an 8-bit core datapath issuing one access per cycle
`ifndef DMBA_DEFINES_VH
`define DMBA_DEFINES_VH
`define DMBA_ADDR_PORT0 8'h00
`define DMBA_ADDR_PTR0 8'h01
`define DMBA_ADDR_PORT1 8'h02
`define DMBA_ADDR_PTR1 8'h03
`define DMBA_ADDR_BANK 8'h04
`define DMBA_ADDR_NVCTL 8'h40
`define DMBA_ADDR_UNUSED 8'h0C
`define DMBA_SFR_TOP 8'h40
`define DMBA_BANK_BIT 0
`define DMBA_BANK_RST 1'b0
`define DMBA_ZERO 8'h00
`endif

/* rtl/dmba_core.v */
// data memory address decode: pointers, bank select, indirect ports, general RAM
// assumes the core presents address, read/write strobes and data synchronous to clk
// assumes sfr_rd_data follows the resolved address within the same cycle
// assumes wdt_idle_rst is held as a level for as long as the watchdog idle reset lasts
// assumes one access per cycle; a write lands in time for the very next access
//
// Overview of operation
// - memory holds a fixed special-function area below the general read/write area.
// - each location is a byte and the address space starts at zero.
// - special-function locations ignore the bank, except nv control at 40H, bank 1 only.
// - a port location stores nothing and forwards the access to its paired pointer's address.
// - an indirect access that lands on a port location reads zero and writes nothing.
// - both pointers are real registers that also supply the indirect address.
// - pointer 0 accesses always reach bank 0.
// - pointer 1 accesses reach the bank chosen by the bank select.
// - direct accesses always reach bank 0.
// - the bank selection is bit 0 of the bank select register.
// - reset clears the bank selection unless it is a watchdog reset in idle or sleep.
// - bit set/clear works on any location except dedicated protected bits.
// - protected special-function bits ignore program writes.
// - bank select 0 is bank 0, 1 is bank 1, upper bits read zero.

module dmba_core #(
  parameter GP_DEPTH = 64,
  parameter [7:0] PROT_MASK = 8'h00
)(
  input wire clk,
  input wire arst_n,
  input wire wdt_idle_rst,
  input wire [7:0] addr,
  input wire rd_en,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire bit_op,
  input wire [2:0] bit_sel,
  input wire bit_val,
  output reg [7:0] rd_data_q,
  output reg [7:0] sfr_addr_q,
  output reg sfr_wr_q,
  output reg [7:0] sfr_wr_data_q,
  output reg sfr_rd_q,
  input wire [7:0] sfr_rd_data,
  output reg nv_sel_q
);
`include "dmba_defines.vh"

  reg [7:0] ptr0_q;
  reg [7:0] ptr1_q;
  reg bank_q;
  reg [7:0] mem_q [0:2*GP_DEPTH-1];
  reg [7:0] eff_addr;
  reg eff_bank;
  reg indirect;
  reg [7:0] cur;
  reg [7:0] wval;
  reg gp_hit;
  reg [6:0] gp_idx;
  reg [7:0] gp_off;
  integer i;

  // ----------------------------------------
  // effective address
  // ----------------------------------------
  always @*
  begin
    indirect = 1'b0;
    eff_addr = addr;
    eff_bank = 1'b0;
    if (addr == `DMBA_ADDR_PORT0)
    begin
      indirect = 1'b1;
      eff_addr = ptr0_q;
      eff_bank = 1'b0;
    end
    else if (addr == `DMBA_ADDR_PORT1)
    begin
      indirect = 1'b1;
      eff_addr = ptr1_q;
      eff_bank = bank_q;
    end
    gp_off = eff_addr - `DMBA_SFR_TOP - 8'h01;
    gp_hit = (eff_addr > `DMBA_SFR_TOP) && (gp_off < GP_DEPTH);
    gp_idx = {eff_bank, gp_off[5:0]};
  end

  // ----------------------------------------
  // current value of the target location
  // ----------------------------------------
  always @*
  begin
    cur = `DMBA_ZERO;
    if (indirect && (eff_addr == `DMBA_ADDR_PORT0 || eff_addr == `DMBA_ADDR_PORT1))
      cur = `DMBA_ZERO;
    else if (eff_addr == `DMBA_ADDR_PTR0)
      cur = ptr0_q;
    else if (eff_addr == `DMBA_ADDR_PTR1)
      cur = ptr1_q;
    else if (eff_addr == `DMBA_ADDR_BANK)
      cur = {7'h00, bank_q};
    else if (eff_addr == `DMBA_ADDR_UNUSED)
      cur = `DMBA_ZERO;
    // nv control only in bank 1
    else if (eff_addr == `DMBA_ADDR_NVCTL)
      cur = eff_bank ? sfr_rd_data : `DMBA_ZERO;
    else if (eff_addr < `DMBA_SFR_TOP)
      cur = sfr_rd_data;
    else if (gp_hit)
      cur = mem_q[gp_idx];
    wval = wr_data;
    if (bit_op)
    begin
      wval = cur;
      wval[bit_sel] = bit_val;
    end
  end

  // ----------------------------------------
  // access qualifiers
  // ----------------------------------------
  // a pointer aimed back at a port would otherwise loop the access
  wire port_loop = indirect &&
    (eff_addr == `DMBA_ADDR_PORT0 || eff_addr == `DMBA_ADDR_PORT1);
  wire do_wr = wr_en && !port_loop;
  wire sfr_hit = (eff_addr < `DMBA_SFR_TOP && eff_addr > `DMBA_ADDR_BANK &&
    eff_addr != `DMBA_ADDR_UNUSED) || (eff_addr == `DMBA_ADDR_NVCTL && eff_bank);
  // nv select only on a real access
  wire nv_hit = (rd_en || wr_en) && (eff_addr == `DMBA_ADDR_NVCTL) && eff_bank;

  // ----------------------------------------
  // bank select
  // ----------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      bank_q <= `DMBA_BANK_RST;
    else if (wdt_idle_rst)
      bank_q <= bank_q;
    else if (do_wr && eff_addr == `DMBA_ADDR_BANK)
      bank_q <= wval[`DMBA_BANK_BIT];
  end

  // ----------------------------------------
  // memory pointers
  // ----------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ptr0_q <= `DMBA_ZERO;
      ptr1_q <= `DMBA_ZERO;
    end
    else
    begin
      if (do_wr && eff_addr == `DMBA_ADDR_PTR0)
        ptr0_q <= wval;
      if (do_wr && eff_addr == `DMBA_ADDR_PTR1)
        ptr1_q <= wval;
    end
  end

  // ----------------------------------------
  // general RAM
  // ----------------------------------------
  // no reset; contents are undefined at power-up
  always @(posedge clk)
  begin
    for (i = 0; i < 2*GP_DEPTH; i = i + 1)
      if (do_wr && gp_hit && gp_idx == i[6:0])
        mem_q[i] <= wval;
  end

  // ----------------------------------------
  // read data toward the core
  // ----------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data_q <= `DMBA_ZERO;
    else if (rd_en)
      rd_data_q <= cur;
    else
      rd_data_q <= `DMBA_ZERO;
  end

  // ----------------------------------------
  // strobes toward special-function registers
  // ----------------------------------------
  // decode runs every cycle; only the strobes say whether it counts
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sfr_addr_q <= `DMBA_ZERO;
      sfr_wr_q <= 1'b0;
      sfr_wr_data_q <= `DMBA_ZERO;
      sfr_rd_q <= 1'b0;
      nv_sel_q <= 1'b0;
    end
    else
    begin
      sfr_addr_q <= eff_addr;
      sfr_wr_q <= do_wr && sfr_hit;
      sfr_wr_data_q <= (wval & ~PROT_MASK) | (cur & PROT_MASK);
      sfr_rd_q <= rd_en && sfr_hit;
      nv_sel_q <= nv_hit;
    end
  end

endmodule // dmba_core

/* testbench/dmba_core_sva.sv */
// port checker for dmba_core
// assumes one clock and async low reset
module dmba_core_sva(input wire clk, arst_n, rd_en, wr_en, bit_op, sfr_wr_q, sfr_rd_q,
  nv_sel_q, input wire [7:0] addr, wr_data, rd_data_q, sfr_addr_q, sfr_wr_data_q,
  sfr_rd_data);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire sfr = addr > 8'h04 && addr < 8'h40 && addr != 8'h0C;
  AST_RD_IDLE: assert property (!rd_en |=> rd_data_q == 8'h00)
    else $error("read data not zero");
  AST_SFR_RD: assert property (rd_en && sfr |=> sfr_rd_q && rd_data_q == $past(sfr_rd_data))
    else $error("sfr read lost");
  AST_SFR_WR: assert property (wr_en && !bit_op && sfr |=> sfr_wr_q &&
    sfr_addr_q == $past(addr) && sfr_wr_data_q == $past(wr_data)) else $error("sfr write");
  AST_IDLE: assert property (!rd_en && !wr_en |=> !sfr_wr_q && !sfr_rd_q && !nv_sel_q)
    else $error("strobe without access");
  AST_UNUSED: assert property ((rd_en || wr_en) && (addr == 8'h0C || addr == 8'h40)
    |=> rd_data_q == 8'h00 && !sfr_wr_q && !nv_sel_q) else $error("unused answered");
  AST_RAM_DIRECT: assert property (wr_en && addr > 8'h40 |=> !sfr_wr_q && !sfr_rd_q)
    else $error("ram write hit sfr");
  AST_NV_PORT1: assert property (nv_sel_q |-> $past(addr) == 8'h02)
    else $error("nv reached not via port one");
  AST_PORT0_NV: assert property ((rd_en || wr_en) && addr == 8'h00 |=> !nv_sel_q)
    else $error("port zero reached bank one");
  AST_BANK_UPPER: assert property (rd_en && addr == 8'h04 |=> rd_data_q[7:1] == 7'h00)
    else $error("bank select upper bits not zero");
endmodule // dmba_core_sva
bind dmba_core dmba_core_sva i_sva(.clk, .arst_n, .rd_en, .wr_en, .bit_op, .sfr_wr_q,
  .sfr_rd_q, .nv_sel_q, .addr, .wr_data, .rd_data_q, .sfr_addr_q, .sfr_wr_data_q,
  .sfr_rd_data);

/* testbench/dmba_sfr_model.sv */
// stand-in sfr file: stores writes, answers the direct address
// limitation: no bank 1 sfr; reads follow addr
module dmba_sfr_model(input wire clk, sfr_wr_q, input wire [7:0] sfr_addr_q,
  sfr_wr_data_q, addr, output wire [7:0] sfr_rd_data);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] mem [0:63];
  always @(posedge clk) if (sfr_wr_q) mem[sfr_addr_q[5:0]] <= sfr_wr_data_q;
  assign sfr_rd_data = mem[addr[5:0]];
endmodule // dmba_sfr_model

/* testbench/data_memory_bank_addressing_tb_top.sv */
// scenario bench for dmba_core
// makes clock and reset itself
module data_memory_bank_addressing_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arst_n = 0, wdt_idle_rst = 0, rd_en = 0, wr_en = 0, bit_op = 0, bit_val = 0;
  logic [2:0] bit_sel = 0;
  logic [7:0] addr = 0, wr_data = 0;
  wire [7:0] rd_data_q, sfr_addr_q, sfr_wr_data_q, sfr_rd_data;
  wire sfr_wr_q, sfr_rd_q, nv_sel_q;
  int err_total = 0, num_checks = 0;
  dmba_core i_dmba_core(.clk, .arst_n, .wdt_idle_rst, .addr, .rd_en, .wr_en, .wr_data,
    .bit_op, .bit_sel, .bit_val, .rd_data_q, .sfr_addr_q, .sfr_wr_q, .sfr_wr_data_q,
    .sfr_rd_q, .sfr_rd_data, .nv_sel_q);
  dmba_sfr_model i_dmba_sfr_model(.clk, .sfr_wr_q, .sfr_addr_q, .sfr_wr_data_q, .addr,
    .sfr_rd_data);
  initial forever #25 clk = ~clk;
  task chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // answer lands at the taking edge, seen at the next falling edge
  task op(logic [7:0] a, logic w, logic [7:0] d);
    @(negedge clk); addr = a; rd_en = !w; wr_en = w; wr_data = d;
    @(negedge clk); rd_en = 0; wr_en = 0;
  endtask
  task t_bank;
    op(8'h04, 1, 8'hFE); op(8'h04, 0, 8'h00);
    chk("bank bit", 8'h00, rd_data_q);
    op(8'h04, 1, 8'hFF); op(8'h04, 0, 8'h00);
    chk("bank", 8'h01, rd_data_q);
  endtask
  task t_ind;
    op(8'h03, 1, 8'h41); op(8'h03, 0, 8'h00); chk("ptr1", 8'h41, rd_data_q);
    op(8'h01, 1, 8'h41); op(8'h41, 1, 8'h55); op(8'h02, 1, 8'hAA);
    op(8'h02, 0, 8'h00); chk("port1 b1", 8'hAA, rd_data_q);
    op(8'h00, 0, 8'h00); chk("port0", 8'h55, rd_data_q);
    op(8'h41, 0, 8'h00); chk("direct", 8'h55, rd_data_q);
    op(8'h04, 1, 8'h00); op(8'h02, 0, 8'h00); chk("port1 b0", 8'h55, rd_data_q);
  endtask
  task t_self;
    op(8'h03, 1, 8'h02); op(8'h02, 0, 8'h00); chk("self", 8'h00, rd_data_q);
    op(8'h03, 1, 8'h40); op(8'h04, 1, 8'h01); op(8'h02, 1, 8'h07);
    chk("nv", 8'h01, {7'h00, nv_sel_q});
    chk("nv addr", 8'h40, sfr_addr_q);
    op(8'h0C, 1, 8'h33); op(8'h0C, 0, 8'h00); chk("unused", 8'h00, rd_data_q);
  endtask
  task t_sfr;
    op(8'h10, 1, 8'h2A); op(8'h10, 0, 8'h00); chk("sfr", 8'h2A, rd_data_q);
    bit_op = 1; bit_sel = 3'h3; bit_val = 1; op(8'h41, 1, 8'h00); bit_op = 0;
    op(8'h41, 0, 8'h00); chk("bitset", 8'h5D, rd_data_q);
  endtask
  task t_rst;
    wdt_idle_rst = 1; op(8'h04, 1, 8'h00); wdt_idle_rst = 0;
    op(8'h04, 0, 8'h00); chk("wdt hold", 8'h01, rd_data_q);
    arst_n = 0; @(negedge clk); arst_n = 1;
    op(8'h04, 0, 8'h00); chk("reset", 8'h00, rd_data_q);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    arst_n = 1;
    t_bank; t_ind; t_self; t_sfr; t_rst;
    wrap_up;
  end
endmodule // data_memory_bank_addressing_tb_top
